// *** rtl/ucr_cfg.svh ***
// constants of the endpoint-0 control request handler
`ifndef UCR_CFG_SVH
`define UCR_CFG_SVH
`define UCR_RT_VEND_OUT 8'h40
`define UCR_RT_VEND_IN 8'hc0
`define UCR_RT_DEV_IN 8'h80
`define UCR_RT_IF_IN 8'h81
`define UCR_RT_EP_IN 8'h82
`define UCR_RT_DEV_OUT 8'h00
`define UCR_RT_EP_OUT 8'h02
`define UCR_RQ_VEND_WR 8'hf1
`define UCR_RQ_VEND_RD 8'hf0
`define UCR_RQ_GET_STATUS 8'h00
`define UCR_RQ_CLR_FEAT 8'h01
`define UCR_RQ_SET_FEAT 8'h03
`define UCR_RQ_GET_DESC 8'h06
`define UCR_RQ_GET_CFG 8'h08
`define UCR_RQ_SET_CFG 8'h09
`define UCR_RQ_GET_IF 8'h0a
`define UCR_FEAT_WAKEUP 16'h0001
`define UCR_FEAT_HALT 16'h0000
`define UCR_DV_DEVICE 16'h0100
`define UCR_DV_CONFIG 16'h0200
`define UCR_DV_LANGS 16'h0300
`define UCR_DT_STRING 8'h03
`define UCR_DEV_DESC_LEN 16'h0012
`define UCR_CFG_DESC_LEN 16'h0027
`define UCR_LANG_DESC_LEN 16'h0004
`define UCR_STATUS_LEN 16'h0002
`define UCR_ONE_BYTE_LEN 16'h0001
`define UCR_SELF_POWERED 1'b1
`define UCR_OFF_CTRL 8'h00
`define UCR_OFF_STAT 8'h04
`define UCR_CTRL_RST 1'b1
`define UCR_CTRL_EN_BIT 0
`define UCR_STAT_CFG_LSB 8
`endif

// *** rtl/ucr_ctrl_handler.sv ***
// endpoint-0 control request handler with AHB-Lite status/control slave
//
// Register access over AHB-Lite and the register offsets were chosen for this implementation.
`include "ucr_cfg.svh"
`default_nettype none
// Notes on behaviour
// R01: vendor write is type 40, request F1; index low byte is first register
// R02: length-one vendor write stores the value low byte at the index
// R03: longer vendor writes store data-stage bytes to consecutive registers
// R04: burst bytes arrive in 8-byte OUT packets, last one shorter
// R05: device status returns wakeup flag in bit 1, self powered bit 0
// R06: endpoint status decodes 00/80,81,02,83 and returns that halt flag
// R07: device descriptor is 18 bytes with the fixed fields and eeprom ids
// R08: every reply is cut to the setup length field
// R09: configuration set is 39 bytes, attributes E0, power from eeprom
// R10: interface descriptor: three endpoints, class FF, subclass E0, FF
// R11: bulk endpoints 81 and 02, attribute 02, 64-byte packets
// R12: interrupt endpoint 83, attribute 03, 8 bytes, eeprom interval
// R13: string index 0 returns 04 03 09 04
// R14: strings 1..3 reply length, type 03, then the eeprom string
// R15: interface status two zeros, get-interface zero, get-config value
// R16: feature requests set or clear wakeup and endpoint halt flags
// R17: vendor read type C0 request F0 returns consecutive registers
// R18: zero eeprom interval disables the interrupt endpoint
module ucr_ctrl_handler (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic bus_reset,
  input wire logic setup_valid,
  input wire logic [7:0] setup_req_type,
  input wire logic [7:0] setup_request,
  input wire logic [15:0] setup_value,
  input wire logic [15:0] setup_index,
  input wire logic [15:0] setup_length,
  input wire logic out_valid,
  input wire logic [7:0] out_data,
  output logic in_valid,
  output logic [7:0] in_data,
  input wire logic in_ready,
  output logic req_done,
  output logic req_stall,
  output logic reg_wr_en,
  output logic [7:0] target_register_index,
  output logic [7:0] reg_wr_data,
  output logic [7:0] reg_rd_index,
  input wire logic [7:0] reg_rd_data,
  output logic [7:0] ee_rd_addr,
  input wire logic [7:0] ee_rd_data,
  input wire logic [15:0] vendor_id,
  input wire logic [15:0] product_id,
  input wire logic [7:0] max_power,
  input wire logic [7:0] status_poll_period,
  input wire logic [7:0] manu_str_len,
  input wire logic [7:0] manu_str_word,
  input wire logic [7:0] prod_str_len,
  input wire logic [7:0] prod_str_word,
  input wire logic [7:0] serial_str_len,
  input wire logic [7:0] serial_str_word,
  output logic remote_wakeup,
  output logic endpoint0_stall_flag,
  output logic endpoint1_stall_flag,
  output logic endpoint2_stall_flag,
  output logic endpoint3_stall_flag,
  output logic int_ep_enable,
  output logic [7:0] config_value,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata
);
  ucr_pkg::ucr_state_t state_ff;
  ucr_pkg::ucr_kind_t kind_ff;
  logic [15:0] tx_len_ff, tx_cnt_ff, wr_len_ff, wr_cnt_ff;
  logic [7:0] rd_ptr_ff, wr_idx_ff, stat_ff, str_len_ff;
  logic in_valid_ff, done_ff, stall_ff, wr_en_ff;
  logic [7:0] in_data_ff, wr_data_ff, wr_tgt_ff, cfg_ff;
  logic wake_ff, int_en_ff, ctrl_en_ff, ahb_wr_ff, hready_ff;
  logic [3:0] ep_stall_ff;
  logic [7:0] ahb_addr_ff;
  logic [31:0] hrdata_ff;

  // bytes of the fixed descriptors, eeprom fields spliced in
  function automatic logic [7:0] dev_byte(input logic [4:0] i,
                                          input logic [15:0] vid,
                                          input logic [15:0] pid);
    logic [7:0] t [0:17];
    t = '{8'h12, 8'h01, 8'h10, 8'h01, 8'hff, 8'h00, 8'hff, 8'h08,
          vid[7:0], vid[15:8], pid[7:0], pid[15:8],
          8'h01, 8'h01, 8'h01, 8'h02, 8'h03, 8'h01};
    dev_byte = (i < 5'd18) ? t[i] : 8'h00;
  endfunction : dev_byte

  // config, interface, two bulk and one interrupt endpoint, 39 bytes
  function automatic logic [7:0] cfg_byte(input logic [5:0] i,
                                          input logic [7:0] pwr,
                                          input logic [7:0] ivl);
    logic [7:0] t [0:38];
    t = '{8'h09, 8'h02, 8'h27, 8'h00, 8'h01, 8'h00, 8'h00, 8'he0, pwr,
          8'h09, 8'h04, 8'h00, 8'h00, 8'h03, 8'hff, 8'he0, 8'hff, 8'h00, // R10
          8'h07, 8'h05, 8'h81, 8'h02, 8'h40, 8'h00, 8'h00, // R11
          8'h07, 8'h05, 8'h02, 8'h02, 8'h40, 8'h00, 8'h00, // R11
          8'h07, 8'h05, 8'h83, 8'h03, 8'h08, 8'h00, ivl}; // R12
    cfg_byte = (i < 6'd39) ? t[i] : 8'h00;
  endfunction : cfg_byte

  function automatic logic [15:0] min16(input logic [15:0] a,
                                        input logic [15:0] b);
    min16 = (a < b) ? a : b;
  endfunction : min16

  wire srst = !rst_b || bus_reset;
  wire [7:0] idx_lo = setup_index[7:0];
  wire [7:0] dsc_idx = setup_value[7:0];
  wire rq_clr = setup_request == `UCR_RQ_CLR_FEAT;
  wire rq_set = setup_request == `UCR_RQ_SET_FEAT;
  // the endpoint number sits in the two low index bits for all four
  wire ep_ok = idx_lo == 8'h00 || idx_lo == 8'h80 || idx_lo == 8'h81 ||
               idx_lo == 8'h02 || idx_lo == 8'h83; // R06
  wire [1:0] ep_num = idx_lo[1:0];
  wire str_ok = dsc_idx >= 8'h01 && dsc_idx <= 8'h03;
  wire [7:0] sel_len = dsc_idx == 8'h01 ? manu_str_len :
                       dsc_idx == 8'h02 ? prod_str_len : serial_str_len;
  wire [7:0] sel_word = dsc_idx == 8'h01 ? manu_str_word :
                        dsc_idx == 8'h02 ? prod_str_word : serial_str_word;

  wire q_vwr = setup_req_type == `UCR_RT_VEND_OUT &&
               setup_request == `UCR_RQ_VEND_WR &&
               setup_index[15:8] == 8'h00; // R01
  wire q_vrd = setup_req_type == `UCR_RT_VEND_IN &&
               setup_request == `UCR_RQ_VEND_RD; // R17
  wire q_gsd = setup_req_type == `UCR_RT_DEV_IN &&
               setup_request == `UCR_RQ_GET_STATUS;
  wire q_gsi = setup_req_type == `UCR_RT_IF_IN &&
               setup_request == `UCR_RQ_GET_STATUS;
  wire q_gse = setup_req_type == `UCR_RT_EP_IN &&
               setup_request == `UCR_RQ_GET_STATUS && ep_ok;
  wire q_gd = setup_req_type == `UCR_RT_DEV_IN &&
              setup_request == `UCR_RQ_GET_DESC;
  wire q_gdd = q_gd && setup_value == `UCR_DV_DEVICE;
  wire q_gdc = q_gd && setup_value == `UCR_DV_CONFIG;
  wire q_gdl = q_gd && setup_value == `UCR_DV_LANGS;
  wire q_gds = q_gd && setup_value[15:8] == `UCR_DT_STRING && str_ok;
  wire q_gcf = setup_req_type == `UCR_RT_DEV_IN &&
               setup_request == `UCR_RQ_GET_CFG;
  wire q_gif = setup_req_type == `UCR_RT_IF_IN &&
               setup_request == `UCR_RQ_GET_IF;
  wire q_scf = setup_req_type == `UCR_RT_DEV_OUT &&
               setup_request == `UCR_RQ_SET_CFG;
  wire q_fwk = setup_req_type == `UCR_RT_DEV_OUT && (rq_clr || rq_set) &&
               setup_value == `UCR_FEAT_WAKEUP;
  wire q_fep = setup_req_type == `UCR_RT_EP_OUT && (rq_clr || rq_set) &&
               setup_value == `UCR_FEAT_HALT && ep_ok;

  wire q_in = q_vrd || q_gsd || q_gsi || q_gse || q_gdd || q_gdc ||
              q_gdl || q_gds || q_gcf || q_gif;
  wire q_burst = q_vwr && setup_length > 16'h0001; // R03
  wire q_single = q_vwr && setup_length == 16'h0001; // R02
  wire q_nodata = q_scf || q_fwk || q_fep || (q_vwr && !q_burst);
  // disabled by software: every request is refused with a stall
  wire accept = ctrl_en_ff && (q_in || q_nodata || q_burst);
  wire take = setup_valid && accept;

  wire ucr_pkg::ucr_kind_t dec_kind =
    q_gdd ? ucr_pkg::K_DEV : q_gdc ? ucr_pkg::K_CFG :
    q_gdl ? ucr_pkg::K_LANG : q_gds ? ucr_pkg::K_STR :
    q_vrd ? ucr_pkg::K_VRD : ucr_pkg::K_STAT;
  wire [15:0] dec_len = q_gdd ? `UCR_DEV_DESC_LEN :
                        q_gdc ? `UCR_CFG_DESC_LEN :
                        q_gdl ? `UCR_LANG_DESC_LEN :
                        q_gds ? {8'h00, sel_len} :
                        q_vrd ? setup_length :
                        (q_gcf || q_gif) ? `UCR_ONE_BYTE_LEN :
                        `UCR_STATUS_LEN; // R15
  wire [7:0] dec_stat = q_gsd ? {6'h00, wake_ff, `UCR_SELF_POWERED} : // R05
                        q_gse ? {7'h00, ep_stall_ff[ep_num]} : // R06
                        q_gcf ? cfg_ff : 8'h00; // R15
  // strings sit at a word offset in the eeprom, length and type first
  wire [7:0] dec_ptr = q_vrd ? idx_lo : {sel_word[6:0], 1'b0};

  wire ld = !in_valid_ff || in_ready;
  wire tx_more = tx_cnt_ff < tx_len_ff;
  wire wr_last = wr_cnt_ff + 16'h0001 == wr_len_ff;
  wire [7:0] cur_byte =
    kind_ff == ucr_pkg::K_DEV ?
      dev_byte(tx_cnt_ff[4:0], vendor_id, product_id) : // R07
    kind_ff == ucr_pkg::K_CFG ?
      cfg_byte(tx_cnt_ff[5:0], max_power, status_poll_period) : // R09
    kind_ff == ucr_pkg::K_LANG ?
      (tx_cnt_ff[1:0] == 2'd0 ? 8'h04 : tx_cnt_ff[1:0] == 2'd1 ? 8'h03 :
       tx_cnt_ff[1:0] == 2'd2 ? 8'h09 : 8'h04) : // R13
    kind_ff == ucr_pkg::K_STR ?
      (tx_cnt_ff == 16'h0000 ? str_len_ff :
       tx_cnt_ff == 16'h0001 ? `UCR_DT_STRING : ee_rd_data) : // R14
    kind_ff == ucr_pkg::K_VRD ? reg_rd_data : // R17
    (tx_cnt_ff == 16'h0000 ? stat_ff : 8'h00);

  always_ff @(posedge clk) begin
    if (srst) begin
      state_ff <= ucr_pkg::ST_IDLE;
      kind_ff <= ucr_pkg::K_STAT;
      tx_len_ff <= 16'h0000;
      wr_len_ff <= 16'h0000;
      stat_ff <= 8'h00;
      str_len_ff <= 8'h00;
    end else if (setup_valid) begin
      state_ff <= !accept ? ucr_pkg::ST_IDLE :
                  q_in ? ucr_pkg::ST_SEND :
                  q_burst ? ucr_pkg::ST_WRITE : ucr_pkg::ST_IDLE;
      kind_ff <= dec_kind;
      tx_len_ff <= min16(dec_len, setup_length); // R08
      wr_len_ff <= setup_length;
      stat_ff <= dec_stat;
      str_len_ff <= sel_len;
    end else begin
      case (state_ff)
        ucr_pkg::ST_SEND: begin
          if (ld && !tx_more) begin
            state_ff <= ucr_pkg::ST_IDLE;
          end
        end
        ucr_pkg::ST_WRITE: begin
          if (out_valid && wr_last) begin
            state_ff <= ucr_pkg::ST_IDLE;
          end
        end
        default: state_ff <= ucr_pkg::ST_IDLE;
      endcase
    end
  end

  // data stage counters and the read pointer shared by registers and eeprom
  always_ff @(posedge clk) begin
    if (srst) begin
      tx_cnt_ff <= 16'h0000;
      rd_ptr_ff <= 8'h00;
      wr_cnt_ff <= 16'h0000;
      wr_idx_ff <= 8'h00;
    end else if (setup_valid) begin
      tx_cnt_ff <= 16'h0000;
      rd_ptr_ff <= dec_ptr;
      wr_cnt_ff <= 16'h0000;
      wr_idx_ff <= idx_lo;
    end else if (state_ff == ucr_pkg::ST_SEND && ld && tx_more) begin
      tx_cnt_ff <= tx_cnt_ff + 16'h0001;
      rd_ptr_ff <= rd_ptr_ff + 8'h01;
    end else if (state_ff == ucr_pkg::ST_WRITE && out_valid) begin
      wr_cnt_ff <= wr_cnt_ff + 16'h0001; // R04
      wr_idx_ff <= wr_idx_ff + 8'h01; // R03
    end
  end

  always_ff @(posedge clk) begin
    if (srst || setup_valid) begin
      in_valid_ff <= 1'b0;
      in_data_ff <= 8'h00;
    end else if (state_ff == ucr_pkg::ST_SEND && ld) begin
      in_valid_ff <= tx_more;
      in_data_ff <= tx_more ? cur_byte : 8'h00;
    end
  end

  // register writes: single from the value field, burst from the data stage
  always_ff @(posedge clk) begin
    if (srst) begin
      wr_en_ff <= 1'b0;
      wr_data_ff <= 8'h00;
      wr_tgt_ff <= 8'h00;
    end else if (take && q_single) begin
      wr_en_ff <= 1'b1;
      wr_data_ff <= setup_value[7:0]; // R02
      wr_tgt_ff <= idx_lo;
    end else begin
      wr_en_ff <= !setup_valid && state_ff == ucr_pkg::ST_WRITE && out_valid;
      wr_data_ff <= out_data; // R03
      wr_tgt_ff <= wr_idx_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      done_ff <= 1'b0;
      stall_ff <= 1'b0;
    end else begin
      done_ff <= (take && q_nodata) ||
        (!setup_valid && state_ff == ucr_pkg::ST_SEND && ld && !tx_more) ||
        (!setup_valid && state_ff == ucr_pkg::ST_WRITE && out_valid &&
         wr_last);
      stall_ff <= setup_valid && !accept;
    end
  end

  // device state changed by feature and configuration requests; interrupt enable follows the eeprom interval
  always_ff @(posedge clk) begin
    if (srst) begin
      wake_ff <= 1'b0;
      ep_stall_ff <= 4'h0;
      cfg_ff <= 8'h00;
      int_en_ff <= 1'b0;
    end else begin
      int_en_ff <= status_poll_period != 8'h00; // R18
      if (take && q_fwk) begin
        wake_ff <= rq_set; // R16
      end
      if (take && q_fep) begin
        ep_stall_ff[ep_num] <= rq_set; // R16
      end
      if (take && q_scf) begin
        cfg_ff <= setup_value[7:0];
      end
    end
  end

  // ahb-lite slave, zero wait states, always OKAY
  wire ahb_go = hsel && htrans[1] && hready;
  wire [31:0] stat_word = {16'h0000, cfg_ff, 1'b0,
                           state_ff != ucr_pkg::ST_IDLE, int_en_ff,
                           ep_stall_ff, wake_ff};
  wire [31:0] rd_mux = haddr[7:0] == `UCR_OFF_CTRL ? {31'h0, ctrl_en_ff} :
                       haddr[7:0] == `UCR_OFF_STAT ? stat_word : 32'h0;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ahb_wr_ff <= 1'b0;
      ahb_addr_ff <= 8'h00;
      hrdata_ff <= 32'h0;
      hready_ff <= 1'b1;
      ctrl_en_ff <= `UCR_CTRL_RST;
    end else begin
      hready_ff <= 1'b1;
      ahb_wr_ff <= ahb_go && hwrite;
      ahb_addr_ff <= haddr[7:0];
      if (ahb_go && !hwrite) begin
        hrdata_ff <= rd_mux;
      end
      if (ahb_wr_ff && ahb_addr_ff == `UCR_OFF_CTRL) begin
        ctrl_en_ff <= hwdata[`UCR_CTRL_EN_BIT];
      end
    end
  end

  assign in_valid = in_valid_ff;
  assign in_data = in_data_ff;
  assign req_done = done_ff;
  assign req_stall = stall_ff;
  assign reg_wr_en = wr_en_ff;
  assign target_register_index = wr_tgt_ff;
  assign reg_wr_data = wr_data_ff;
  assign reg_rd_index = rd_ptr_ff;
  assign ee_rd_addr = rd_ptr_ff;
  assign remote_wakeup = wake_ff;
  assign endpoint0_stall_flag = ep_stall_ff[0];
  assign endpoint1_stall_flag = ep_stall_ff[1];
  assign endpoint2_stall_flag = ep_stall_ff[2];
  assign endpoint3_stall_flag = ep_stall_ff[3];
  assign int_ep_enable = int_en_ff;
  assign config_value = cfg_ff;
  assign hreadyout = hready_ff;
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  single_write_a: assert property ( // R02
    take && q_single |=> reg_wr_en &&
      reg_wr_data == $past(setup_value[7:0]) &&
      target_register_index == $past(idx_lo))
    else $error("single vendor write not stored");
  burst_bound_a: assert property ( // R03
    state_ff == ucr_pkg::ST_WRITE |-> wr_cnt_ff < wr_len_ff)
    else $error("burst write past its length");
  burst_step_a: assert property ( // R04
    reg_wr_en && $past(state_ff) == ucr_pkg::ST_WRITE ##1 reg_wr_en &&
      $past(state_ff) == ucr_pkg::ST_WRITE |->
      target_register_index == $past(target_register_index) + 8'h01)
    else $error("burst write index not consecutive");
  trunc_len_a: assert property ( // R08
    $rose(state_ff == ucr_pkg::ST_SEND) |->
      tx_len_ff <= $past(setup_length))
    else $error("reply longer than setup length");
  dev_status_a: assert property ( // R05
    take && q_gsd && setup_length != 16'h0 ##1 !setup_valid [*2] |->
      in_valid && in_data == {6'h00, wake_ff, 1'b1})
    else $error("device status byte wrong");
  ep_status_a: assert property ( // R06
    take && q_gse && setup_length != 16'h0 ##1 !setup_valid [*2] |->
      in_valid && in_data == {7'h00, $past(ep_stall_ff[ep_num], 2)})
    else $error("endpoint status byte wrong");
  dev_desc_a: assert property ( // R07
    take && q_gdd && setup_length != 16'h0 ##1 !setup_valid [*2] |->
      in_data == 8'h12)
    else $error("device descriptor does not open with 12");
  lang_desc_a: assert property ( // R13
    take && q_gdl && setup_length != 16'h0 ##1 !setup_valid [*2] |->
      in_data == 8'h04)
    else $error("language descriptor does not open with 04");
  wake_feat_a: assert property ( // R16
    take && q_fwk |=> remote_wakeup == $past(rq_set) && req_done)
    else $error("remote wakeup feature not applied");
  poll_dis_a: assert property ( // R18
    status_poll_period == 8'h00 ##1 status_poll_period == 8'h00 |->
      !int_ep_enable)
    else $error("interrupt endpoint enabled with zero interval");

  burst_done_c: cover property (
    state_ff == ucr_pkg::ST_WRITE ##1 state_ff == ucr_pkg::ST_IDLE);
  cfg_sent_c: cover property (
    kind_ff == ucr_pkg::K_CFG && tx_cnt_ff == 16'h0027 && req_done);
  vend_read_c: cover property (
    kind_ff == ucr_pkg::K_VRD && in_valid && in_ready);
  stall_c: cover property (req_stall);
endmodule : ucr_ctrl_handler
`default_nettype wire

// *** rtl/ucr_pkg.sv ***
// types of the endpoint-0 control request handler
`default_nettype none
package ucr_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WRITE = 3'b010,
    ST_SEND = 3'b100
  } ucr_state_t;
  typedef enum logic [2:0] {
    K_DEV = 3'h0,
    K_CFG = 3'h1,
    K_LANG = 3'h2,
    K_STR = 3'h3,
    K_STAT = 3'h4,
    K_VRD = 3'h5
  } ucr_kind_t;
endpackage : ucr_pkg
`default_nettype wire

// *** verification/ucr_ctrl_handler_tb.sv ***
// self-checking bench of the control request handler
`default_nettype none
module ucr_ctrl_handler_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_b, bus_reset, setup_valid, out_valid, slow;
  logic [3:0] ep_flags;
  logic in_valid, in_ready, req_done, req_stall, reg_wr_en, hwrite;
  logic remote_wakeup, int_ep_enable, hsel, hreadyout, hresp;
  logic [7:0] setup_req_type, setup_request, out_data, in_data, d;
  logic [7:0] target_register_index, reg_wr_data, reg_rd_index;
  logic [7:0] reg_rd_data, ee_rd_addr, ee_rd_data, max_power;
  logic [7:0] status_poll_period, config_value;
  logic [7:0] str_len [1:3];
  logic [7:0] str_word [1:3];
  logic [7:0] eps [5] = '{8'h80, 8'h00, 8'h81, 8'h02, 8'h83};
  logic [15:0] setup_value, setup_index, setup_length;
  logic [15:0] vendor_id, product_id, exp_w;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [7:0] exp_q [$];
  logic [15:0] wr_q [$];
  int mismatches, samples_checked, done_n, stall_n, d0, s0;
  int seed = 32;

  ucr_ctrl_handler ucr_ctrl_handler_i (
    .clk(clk), .rst_b(rst_b), .bus_reset(bus_reset),
    .setup_valid(setup_valid), .setup_req_type(setup_req_type),
    .setup_request(setup_request), .setup_value(setup_value),
    .setup_index(setup_index), .setup_length(setup_length),
    .out_valid(out_valid), .out_data(out_data), .in_valid(in_valid),
    .in_data(in_data), .in_ready(in_ready), .req_done(req_done),
    .req_stall(req_stall), .reg_wr_en(reg_wr_en),
    .target_register_index(target_register_index),
    .reg_wr_data(reg_wr_data), .reg_rd_index(reg_rd_index),
    .reg_rd_data(reg_rd_data), .ee_rd_addr(ee_rd_addr),
    .ee_rd_data(ee_rd_data), .vendor_id(vendor_id),
    .product_id(product_id), .max_power(max_power),
    .status_poll_period(status_poll_period),
    .manu_str_len(str_len[1]), .manu_str_word(str_word[1]),
    .prod_str_len(str_len[2]), .prod_str_word(str_word[2]),
    .serial_str_len(str_len[3]), .serial_str_word(str_word[3]),
    .remote_wakeup(remote_wakeup), .endpoint0_stall_flag(ep_flags[0]),
    .endpoint1_stall_flag(ep_flags[1]), .endpoint2_stall_flag(ep_flags[2]),
    .endpoint3_stall_flag(ep_flags[3]), .int_ep_enable(int_ep_enable),
    .config_value(config_value), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata));

  ucr_host_model ucr_host_model_i (.clk(clk), .rst_b(rst_b), .slow(slow),
    .in_ready(in_ready), .reg_rd_index(reg_rd_index),
    .reg_rd_data(reg_rd_data), .ee_rd_addr(ee_rd_addr),
    .ee_rd_data(ee_rd_data));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input string what, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic end_of_test();
    if (mismatches == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test

  // results land at clock edges: noted in queues, taken off here
  always @(posedge clk) begin
    if (req_done === 1'b1) done_n++;
    if (req_stall === 1'b1) stall_n++;
    if (in_valid === 1'b1 && in_ready === 1'b1) begin
      if (exp_q.size() == 0) chk("in_extra", 32'h1, 32'h0);
      else chk("in_data", {24'h0, in_data}, {24'h0, exp_q.pop_front()});
    end
    if (reg_wr_en === 1'b1) begin
      exp_w = (wr_q.size() == 0) ? 16'hxxxx : wr_q.pop_front();
      chk("reg_wr", {16'h0, target_register_index, reg_wr_data},
          {16'h0, exp_w});
    end
  end

  task automatic setup(input logic [7:0] rt, rq, input logic [15:0] v, ix, ln);
    @(posedge clk);
    d0 = done_n;
    s0 = stall_n;
    setup_valid <= 1'b1;
    setup_req_type <= rt;
    setup_request <= rq;
    setup_value <= v;
    setup_index <= ix;
    setup_length <= ln;
    @(posedge clk);
    setup_valid <= 1'b0;
  endtask : setup

  task automatic finish_req(input int st);
    int n;
    n = 0;
    while (done_n == d0 && stall_n == s0 && n < 600) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("finished", {31'h0, n < 600}, 32'h1);
    chk("stalled", 32'(stall_n - s0), 32'(st));
    chk("leftover", 32'(exp_q.size() + wr_q.size()), 32'h0);
  endtask : finish_req

  task automatic req(input logic [7:0] rt, rq, input logic [15:0] v, ix, ln,
      input int st);
    setup(rt, rq, v, ix, ln);
    finish_req(st);
  endtask : req

  task automatic ahb(input logic wr, input logic [31:0] a, wd,
      output logic [31:0] r);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    r = hrdata;
    chk("hresp", {31'h0, hresp}, 32'h0);
  endtask : ahb

  initial begin
    #(40 * 40000);
    mismatches++;
    end_of_test();
  end

  initial begin
    {bus_reset, setup_valid, out_valid, slow, hsel, hwrite} = '0;
    {setup_req_type, setup_request, out_data, htrans} = '0;
    {setup_value, setup_index, setup_length, haddr, hwdata} = '0;
    vendor_id = 16'($random(seed));
    product_id = 16'($random(seed));
    max_power = 8'($random(seed));
    status_poll_period = 8'($random(seed)) | 8'h01;
    str_len = '{8'h06, 8'h04, 8'h08};
    str_word = '{8'h10, 8'h18, 8'h38};
    rst_b = 1'b0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    chk("int_ep", {31'h0, int_ep_enable}, 32'h1);
    req(8'h00, 8'h03, 16'h1, 16'h0, 16'h0, 0);
    exp_q = '{8'h03, 8'h00};
    req(8'h80, 8'h00, 16'h0, 16'h0, 16'h2, 0);
    ahb(1'b0, 32'h4, 32'h0, rd);
    chk("wake_bit", {31'h0, rd[0]}, 32'h1);
    req(8'h00, 8'h01, 16'h1, 16'h0, 16'h0, 0);
    exp_q = '{8'h01, 8'h00};
    req(8'h80, 8'h00, 16'h0, 16'h0, 16'h2, 0);
    req(8'h00, 8'h03, 16'h1, 16'h0, 16'h0, 0);
    @(posedge clk) bus_reset <= 1'b1;
    repeat (2) @(posedge clk);
    bus_reset <= 1'b0;
    @(posedge clk);
    chk("wake_cleared", {31'h0, remote_wakeup}, 32'h0);
    foreach (eps[i]) begin
      req(8'h02, 8'h03, 16'h0, {8'h0, eps[i]}, 16'h0, 0);
      chk("stall_flags", {28'h0, ep_flags}, 32'h1 << eps[i][1:0]);
      exp_q = '{8'h01, 8'h00};
      req(8'h82, 8'h00, 16'h0, {8'h0, eps[i]}, 16'h2, 0);
      req(8'h02, 8'h01, 16'h0, {8'h0, eps[i]}, 16'h0, 0);
      exp_q = '{8'h00, 8'h00};
      req(8'h82, 8'h00, 16'h0, {8'h0, eps[i]}, 16'h2, 0);
    end
    req(8'h82, 8'h00, 16'h0, 16'h0084, 16'h2, 1);
    exp_q = '{8'h12, 8'h01, 8'h10, 8'h01, 8'hff, 8'h00, 8'hff, 8'h08,
      vendor_id[7:0], vendor_id[15:8], product_id[7:0], product_id[15:8],
      8'h01, 8'h01, 8'h01, 8'h02, 8'h03, 8'h01};
    req(8'h80, 8'h06, 16'h0100, 16'h0, 16'd64, 0);
    exp_q = '{8'h12, 8'h01, 8'h10, 8'h01, 8'hff, 8'h00, 8'hff, 8'h08};
    req(8'h80, 8'h06, 16'h0100, 16'h0, 16'd8, 0);
    slow <= 1'b1;
    exp_q = '{8'h09, 8'h02, 8'h27, 8'h00, 8'h01, 8'h00, 8'h00, 8'he0,
      max_power, 8'h09, 8'h04, 8'h00, 8'h00, 8'h03, 8'hff, 8'he0, 8'hff,
      8'h00, 8'h07, 8'h05, 8'h81, 8'h02, 8'h40, 8'h00, 8'h00, 8'h07, 8'h05,
      8'h02, 8'h02, 8'h40, 8'h00, 8'h00, 8'h07, 8'h05, 8'h83, 8'h03, 8'h08,
      8'h00, status_poll_period};
    req(8'h80, 8'h06, 16'h0200, 16'h0, 16'd255, 0);
    slow <= 1'b0;
    exp_q = '{8'h04, 8'h03, 8'h09, 8'h04};
    req(8'h80, 8'h06, 16'h0300, 16'h0, 16'd255, 0);
    for (int i = 1; i < 4; i++) begin
      exp_q = '{str_len[i], 8'h03};
      for (int k = 2; k < str_len[i]; k++) begin
        exp_q.push_back((str_word[i] * 8'h2 + 8'(k)) ^ 8'ha5);
      end
      req(8'h80, 8'h06, {8'h03, 8'(i)}, 16'h0409, 16'd255, 0);
    end
    req(8'h80, 8'h06, 16'h0304, 16'h0409, 16'd255, 1);
    req(8'h00, 8'h09, 16'h0001, 16'h0, 16'h0, 0);
    chk("cfg_value", {24'h0, config_value}, 32'h1);
    exp_q = '{8'h01};
    req(8'h80, 8'h08, 16'h0, 16'h0, 16'h1, 0);
    exp_q = '{8'h00};
    req(8'h81, 8'h0a, 16'h0, 16'h0, 16'h1, 0);
    exp_q = '{8'h00, 8'h00};
    req(8'h81, 8'h00, 16'h0, 16'h0, 16'h2, 0);
    ahb(1'b0, 32'h4, 32'h0, rd);
    chk("cfg_field", {24'h0, rd[15:8]}, 32'h1);
    d = 8'($random(seed));
    wr_q = '{{8'h05, d}};
    req(8'h40, 8'hf1, {8'h00, d}, 16'h0005, 16'h1, 0);
    req(8'h40, 8'hf1, 16'h0, 16'h0105, 16'h1, 1);
    setup(8'h40, 8'hf1, 16'h0, 16'h0007, 16'd20);
    for (int k = 0; k < 20; k++) begin
      // idle between eight-byte packets, as the host would
      if (k % 8 == 0) begin
        out_valid <= 1'b0;
        @(posedge clk);
      end
      d = 8'($random(seed));
      wr_q.push_back({8'h07 + 8'(k), d});
      out_valid <= 1'b1;
      out_data <= d;
      @(posedge clk);
    end
    out_valid <= 1'b0;
    finish_req(0);
    exp_q = '{8'h3a, 8'h3b, 8'h3c};
    req(8'hc0, 8'hf0, 16'h0, 16'h0007, 16'h3, 0);
    ahb(1'b1, 32'h0, 32'h0, rd);
    req(8'h80, 8'h00, 16'h0, 16'h0, 16'h2, 1);
    ahb(1'b1, 32'h0, 32'h1, rd);
    ahb(1'b0, 32'h8, 32'h0, rd);
    chk("unmapped", rd, 32'h0);
    status_poll_period <= 8'h00;
    repeat (4) @(posedge clk);
    chk("int_ep_off", {31'h0, int_ep_enable}, 32'h0);
    end_of_test();
  end
endmodule : ucr_ctrl_handler_tb
`default_nettype wire

// *** verification/ucr_host_model.sv ***
// host side model: takes IN bytes, answers register and eeprom reads
`default_nettype none
module ucr_host_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic slow,
  output logic in_ready,
  input wire logic [7:0] reg_rd_index,
  output logic [7:0] reg_rd_data,
  input wire logic [7:0] ee_rd_addr,
  output logic [7:0] ee_rd_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] pace_ff;
  // a slow host takes one byte in eight, so in_valid must hold
  assign in_ready = slow ? (pace_ff == 3'h3) : 1'b1;
  assign reg_rd_data = reg_rd_index + 8'h33;
  assign ee_rd_data = ee_rd_addr ^ 8'ha5;
  always_ff @(posedge clk) begin
    if (!rst_b) pace_ff <= 3'h0;
    else pace_ff <= pace_ff + 3'h1;
  end
endmodule : ucr_host_model
`default_nettype wire
